// *** rtl/imc_top.sv ***
/*
 * imc_top: idle/sleep entry and exit control plus decode of the watchdog and
 * oscillator configuration words, with an Avalon-MM register slave.
 * Assumes a single 25 MHz clock, CPU supplies wait/priority/wake events,
 * and the configuration words are loaded by software or start-up logic.
 */
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`include "imc_cfg.svh"

module imc_top #(
    parameter int NPERIPH = 8
) (
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic [`IMC_ADDR_W-1:0]  avs_address_i,
    input  wire logic                    avs_read_i,
    input  wire logic                    avs_write_i,
    input  wire logic [31:0]             avs_writedata_i,
    input  wire logic [3:0]              avs_byteenable_i,
    output logic [31:0]                  avs_readdata_o,
    output logic                         avs_waitrequest_o,
    input  wire logic                    wait_instr_i,
    input  wire logic                    irq_pending_i,
    input  wire logic [2:0]              irq_priority_i,
    input  wire logic [2:0]              cpu_priority_i,
    input  wire logic                    wdt_timeout_i,
    input  wire logic                    soft_reset_i,
    input  wire logic [NPERIPH-1:0]      stop_in_idle_i,
    output logic                         cpu_halt_o,
    output logic                         in_idle_o,
    output logic                         in_sleep_o,
    output logic [NPERIPH-1:0]           periph_run_o,
    output imc_pkg::imc_cfg_s            cfg_o
);

    imc_pkg::imc_state_s st_reg;
    imc_pkg::imc_state_s st_next;

    logic       acc;
    logic       wake;
    logic [4:0] rps;
    logic [4:0] sps;

    // postscale codes above the top figure all mean the same divide
    function automatic logic [4:0] imc_ps_clip(input logic [4:0] code);
        imc_ps_clip = (code >= `IMC_PS_MAX) ? `IMC_PS_MAX : code;
    endfunction : imc_ps_clip

    always_comb
    begin
        st_next = st_reg;
        acc = avs_read_i | avs_write_i;
        // wake needs a strictly higher priority; equal priority stays halted
        wake = (irq_pending_i && (irq_priority_i > cpu_priority_i))
             || wdt_timeout_i
             || soft_reset_i;
        st_next.rvalid = acc & ~st_reg.rvalid;
        if (acc && !st_reg.rvalid && avs_write_i)
        begin
            unique case (avs_address_i)
                `IMC_OFS_OSC_CTRL:
                begin
                    if (st_reg.unlock == imc_pkg::IMC_UL_OPEN && avs_byteenable_i[0])
                    begin
                        st_next.sleep_sel = avs_writedata_i[`IMC_BIT_SLEEP_SEL];
                    end
                end
                `IMC_OFS_UNLOCK:
                begin
                    if (avs_writedata_i == `IMC_UNLOCK_KEY1)
                    begin
                        st_next.unlock = imc_pkg::IMC_UL_KEY1;
                    end
                    else if (avs_writedata_i == `IMC_UNLOCK_KEY2
                             && st_reg.unlock == imc_pkg::IMC_UL_KEY1)
                    begin
                        st_next.unlock = imc_pkg::IMC_UL_OPEN;
                    end
                    else
                    begin
                        st_next.unlock = imc_pkg::IMC_UL_LOCKED;
                    end
                end
                `IMC_OFS_WDT_WORD:
                begin
                    for (int b = 0; b < 4; b++)
                    begin
                        if (avs_byteenable_i[b])
                        begin
                            st_next.wdt_word[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
                        end
                    end
                end
                `IMC_OFS_OSC_WORD:
                begin
                    for (int b = 0; b < 4; b++)
                    begin
                        if (avs_byteenable_i[b])
                        begin
                            st_next.osc_word[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end
        if (acc && !st_reg.rvalid && avs_read_i)
        begin
            unique case (avs_address_i)
                `IMC_OFS_OSC_CTRL:
                    st_next.rdata = {24'h000000, 1'b0, st_reg.pwr == imc_pkg::IMC_IDLE,
                                     st_reg.pwr == imc_pkg::IMC_SLEEP, st_reg.sleep_sel,
                                     4'h0};
                `IMC_OFS_UNLOCK:
                    st_next.rdata = {31'h00000000, st_reg.unlock == imc_pkg::IMC_UL_OPEN};
                `IMC_OFS_WDT_WORD:
                    st_next.rdata = st_reg.wdt_word;
                `IMC_OFS_OSC_WORD:
                    st_next.rdata = st_reg.osc_word;
                default:
                    st_next.rdata = 32'h00000000;
            endcase
        end
        unique case (st_reg.pwr)
            imc_pkg::IMC_RUN:
            begin
                if (wait_instr_i)
                begin
                    st_next.pwr = st_reg.sleep_sel ? imc_pkg::IMC_SLEEP
                                                   : imc_pkg::IMC_IDLE;
                end
            end
            imc_pkg::IMC_IDLE, imc_pkg::IMC_SLEEP:
            begin
                if (wake)
                begin
                    st_next.pwr = imc_pkg::IMC_RUN;
                end
            end
            default:
                st_next.pwr = imc_pkg::IMC_RUN;
        endcase
        if (soft_reset_i)
        begin
            st_next.unlock = imc_pkg::IMC_UL_LOCKED;
        end
        st_next.cpu_halt = (st_next.pwr != imc_pkg::IMC_RUN);
        st_next.in_idle  = (st_next.pwr == imc_pkg::IMC_IDLE);
        st_next.in_sleep = (st_next.pwr == imc_pkg::IMC_SLEEP);
        // waitrequest leaves a flop so the bus never sees a decode glitch
        st_next.waitreq  = ~st_next.rvalid;
        for (int p = 0; p < NPERIPH; p++)
        begin
            st_next.periph_run[p] = !(st_next.pwr == imc_pkg::IMC_SLEEP
                || (st_next.pwr == imc_pkg::IMC_IDLE && stop_in_idle_i[p]));
        end
        rps = st_reg.wdt_word[`IMC_WDT_RPS_HI:`IMC_WDT_RPS_LO];
        sps = st_reg.wdt_word[`IMC_WDT_SPS_HI:`IMC_WDT_SPS_LO];
        st_next.cfg.wdt_enable        = st_reg.wdt_word[`IMC_WDT_EN_BIT];
        st_next.cfg.wdt_clk_sel       = imc_pkg::imc_wdt_clk_e'(
            st_reg.wdt_word[`IMC_WDT_CLK_HI:`IMC_WDT_CLK_LO]);
        st_next.cfg.wdt_clk_rsvd      =
            (st_reg.wdt_word[`IMC_WDT_CLK_HI:`IMC_WDT_CLK_LO] == 2'h1);
        st_next.cfg.run_ps_exp        = imc_ps_clip(rps);
        st_next.cfg.sleep_ps_exp      = imc_ps_clip(sps);
        st_next.cfg.wdt_window_en     = ~st_reg.wdt_word[`IMC_WDT_WINDOW_DISABLE_BIT];
        st_next.cfg.clk_switch_en     = st_reg.osc_word[`IMC_OSC_CKSM_LO];
        st_next.cfg.fail_safe_mon_en  = st_reg.osc_word[`IMC_OSC_CKSM_HI];
        st_next.cfg.sec_osc_owns_pins = st_reg.osc_word[`IMC_OSC_SXTAL_BIT];
        st_next.cfg.clk_out_drive     = ~st_reg.osc_word[`IMC_OSC_CLKOUT_BIT];
        st_next.cfg.pri_osc_mode      = imc_pkg::imc_pmode_e'(
            st_reg.osc_word[`IMC_OSC_PMODE_HI:`IMC_OSC_PMODE_LO]);
        st_next.cfg.two_speed_en      = st_reg.osc_word[`IMC_OSC_2SPD_BIT];
        st_next.cfg.sec_osc_en        = st_reg.osc_word[`IMC_OSC_SEN_BIT];
        st_next.cfg.init_osc_sel      =
            st_reg.osc_word[`IMC_OSC_INIT_HI:`IMC_OSC_INIT_LO];
        // the PLL reference is latched only on soft reset, not on every write
        if (soft_reset_i)
        begin
            st_next.cfg.pll_ref_frc = st_reg.osc_word[`IMC_OSC_PLLREF_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_reg <= '0;
            st_reg.pwr <= imc_pkg::IMC_RUN;
            st_reg.wdt_word <= `IMC_WDT_RESET;
            st_reg.osc_word <= `IMC_OSC_RESET;
            st_reg.periph_run <= '1;
            st_reg.waitreq <= 1'b1;
            st_reg.cfg.wdt_enable <= 1'b1;
            st_reg.cfg.wdt_clk_sel <= imc_pkg::IMC_WCLK_LOW_POWER_RC_OSCILLATOR;
            st_reg.cfg.run_ps_exp <= `IMC_PS_MAX;
            st_reg.cfg.sleep_ps_exp <= `IMC_PS_MAX;
            st_reg.cfg.clk_switch_en <= 1'b1;
            st_reg.cfg.fail_safe_mon_en <= 1'b1;
            st_reg.cfg.sec_osc_owns_pins <= 1'b1;
            st_reg.cfg.pri_osc_mode <= imc_pkg::IMC_PMODE_OFF;
            st_reg.cfg.two_speed_en <= 1'b1;
            st_reg.cfg.sec_osc_en <= 1'b1;
            st_reg.cfg.pll_ref_frc <= 1'b1;
            st_reg.cfg.init_osc_sel <= 3'h7;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata_o    = st_reg.rdata;
    assign avs_waitrequest_o = st_reg.waitreq;
    assign cpu_halt_o        = st_reg.cpu_halt;
    assign in_idle_o         = st_reg.in_idle;
    assign in_sleep_o        = st_reg.in_sleep;
    assign periph_run_o      = st_reg.periph_run;
    assign cfg_o             = st_reg.cfg;

    a_idle_entry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_reg.pwr == imc_pkg::IMC_RUN && wait_instr_i && !st_reg.sleep_sel
        |=> in_idle_o && cpu_halt_o)
        else $error("wait with sleep select clear did not enter idle");
    a_sleep_entry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_reg.pwr == imc_pkg::IMC_RUN && wait_instr_i && st_reg.sleep_sel |=> in_sleep_o)
        else $error("wait with sleep select set did not enter sleep");
    a_low_prio_stays: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        in_idle_o && irq_pending_i && irq_priority_i <= cpu_priority_i
        && !wdt_timeout_i && !soft_reset_i |=> in_idle_o)
        else $error("low priority interrupt left idle");
    a_high_prio_wake: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        in_idle_o && irq_pending_i && irq_priority_i > cpu_priority_i |=> !cpu_halt_o)
        else $error("higher priority interrupt did not wake");
    a_reset_wake: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        in_idle_o && soft_reset_i |=> !in_idle_o)
        else $error("reset did not leave idle");
    a_wdt_wake: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        in_idle_o && wdt_timeout_i |=> !in_idle_o)
        else $error("watchdog time-out did not wake");
    a_halt_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        in_idle_o |-> cpu_halt_o)
        else $error("cpu running in idle");
    a_periph_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        in_idle_o && $stable(stop_in_idle_i) && $past(in_idle_o)
        |-> periph_run_o == ~stop_in_idle_i)
        else $error("peripheral run flags wrong in idle");
    a_locked_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        avs_write_i && avs_waitrequest_o && avs_address_i == `IMC_OFS_OSC_CTRL
        && st_reg.unlock != imc_pkg::IMC_UL_OPEN |=> $stable(st_reg.sleep_sel))
        else $error("sleep select changed while locked");
    a_ps_cap: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $past(rps) >= `IMC_PS_MAX |-> cfg_o.run_ps_exp == `IMC_PS_MAX)
        else $error("postscale code not capped");
    a_window: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ##1 cfg_o.wdt_window_en == !$past(st_reg.wdt_word[`IMC_WDT_WINDOW_DISABLE_BIT]))
        else $error("window enable wrong");

    // decode checks: each field except pll_ref_frc follows the word held one edge earlier
    a_wdt_enable: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cfg_o.wdt_enable
        == $past(st_reg.wdt_word[`IMC_WDT_EN_BIT]))
        else $error("watchdog enable wrong");

    a_clk_rsvd: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cfg_o.wdt_clk_rsvd
        == ($past(st_reg.wdt_word[`IMC_WDT_CLK_HI:`IMC_WDT_CLK_LO]) == 2'h1))
        else $error("reserved clock code not flagged");

    a_clk_low_power_rc_oscillator: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $past(st_reg.wdt_word[`IMC_WDT_CLK_HI:`IMC_WDT_CLK_LO]) == 2'h3
        |-> cfg_o.wdt_clk_sel == imc_pkg::IMC_WCLK_LOW_POWER_RC_OSCILLATOR)
        else $error("clock code 3 not low-power source");

    a_ps_pass: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $past(rps) < `IMC_PS_MAX
        |-> cfg_o.run_ps_exp == $past(rps))
        else $error("run postscale altered");

    a_sleep_ps: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $past(sps) >= `IMC_PS_MAX
        |-> cfg_o.sleep_ps_exp == `IMC_PS_MAX)
        else $error("sleep postscale not capped");

    a_clk_monitor: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        {cfg_o.fail_safe_mon_en, cfg_o.clk_switch_en}
        == $past(st_reg.osc_word[`IMC_OSC_CKSM_HI:`IMC_OSC_CKSM_LO]))
        else $error("switching or monitor wrong");

    a_sec_pins: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cfg_o.sec_osc_owns_pins
        == $past(st_reg.osc_word[`IMC_OSC_SXTAL_BIT]))
        else $error("pin ownership wrong");

    a_clk_out: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cfg_o.clk_out_drive
        != $past(st_reg.osc_word[`IMC_OSC_CLKOUT_BIT]))
        else $error("clock output drive wrong");

    a_pri_mode: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cfg_o.pri_osc_mode
        == $past(st_reg.osc_word[`IMC_OSC_PMODE_HI:`IMC_OSC_PMODE_LO]))
        else $error("primary mode wrong");

    a_two_speed: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cfg_o.two_speed_en
        == $past(st_reg.osc_word[`IMC_OSC_2SPD_BIT]))
        else $error("two-speed enable wrong");

    a_sec_osc: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cfg_o.sec_osc_en
        == $past(st_reg.osc_word[`IMC_OSC_SEN_BIT]))
        else $error("secondary enable wrong");

    a_pll_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !$past(soft_reset_i)
        |-> $stable(cfg_o.pll_ref_frc))
        else $error("pll reference moved without reset");

    a_pll_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $past(soft_reset_i)
        |-> cfg_o.pll_ref_frc == $past(st_reg.osc_word[`IMC_OSC_PLLREF_BIT]))
        else $error("pll reference not loaded");

    a_init_osc: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cfg_o.init_osc_sel
        == $past(st_reg.osc_word[`IMC_OSC_INIT_HI:`IMC_OSC_INIT_LO]))
        else $error("initial oscillator wrong");

    a_open_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        avs_write_i && avs_waitrequest_o && avs_address_i == `IMC_OFS_OSC_CTRL
        && avs_byteenable_i[0] && st_reg.unlock == imc_pkg::IMC_UL_OPEN
        |=> st_reg.sleep_sel == $past(avs_writedata_i[`IMC_BIT_SLEEP_SEL]))
        else $error("unlocked sleep select write lost");

    a_reset_lock: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        soft_reset_i |=> st_reg.unlock == imc_pkg::IMC_UL_LOCKED)
        else $error("reset left unlock open");

    c_idle_wake: cover property (@(posedge sys_clk_i) in_idle_o ##1 !cpu_halt_o);
    c_sleep: cover property (@(posedge sys_clk_i) in_sleep_o);
    c_unlock_write: cover property (@(posedge sys_clk_i)
        st_reg.unlock == imc_pkg::IMC_UL_OPEN ##1 st_reg.sleep_sel);
    c_wdt_wake: cover property (@(posedge sys_clk_i) in_idle_o && wdt_timeout_i);
    c_pll_load: cover property (@(posedge sys_clk_i)
        soft_reset_i ##1 !cfg_o.pll_ref_frc);

endmodule : imc_top

// *** rtl/imc_cfg.svh ***
/*
 * imc_cfg.svh: register offsets, field positions and reset values of the
 * idle-mode and clock/watchdog configuration block.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
 */
`ifndef IMC_CFG_SVH
`define IMC_CFG_SVH

`define IMC_ADDR_W          4
`define IMC_OFS_OSC_CTRL    4'h0
`define IMC_OFS_UNLOCK      4'h4
`define IMC_OFS_WDT_WORD    4'h8
`define IMC_OFS_OSC_WORD    4'hC
`define IMC_UNLOCK_KEY1     32'hAA996655
`define IMC_UNLOCK_KEY2     32'h556699AA
`define IMC_BIT_SLEEP_SEL   4
`define IMC_WDT_EN_BIT      15
`define IMC_WDT_CLK_HI      14
`define IMC_WDT_CLK_LO      13
`define IMC_WDT_RPS_HI      12
`define IMC_WDT_RPS_LO      8
`define IMC_WDT_WINDOW_DISABLE_BIT  7
`define IMC_WDT_SPS_HI      4
`define IMC_WDT_SPS_LO      0
`define IMC_OSC_CKSM_HI     15
`define IMC_OSC_CKSM_LO     14
`define IMC_OSC_SXTAL_BIT   12
`define IMC_OSC_CLKOUT_BIT  10
`define IMC_OSC_PMODE_HI    9
`define IMC_OSC_PMODE_LO    8
`define IMC_OSC_2SPD_BIT    7
`define IMC_OSC_SEN_BIT     6
`define IMC_OSC_PLLREF_BIT  4
`define IMC_OSC_INIT_HI     2
`define IMC_OSC_INIT_LO     0
`define IMC_RSVD_ONES       32'hFFFF0000
`define IMC_OSC_RSVD_ONES   32'h0000_2828
`define IMC_WDT_RESET       32'hFFFFFFFF
`define IMC_OSC_RESET       32'hFFFFFFFF
`define IMC_PS_MAX          5'h14

`endif

// *** rtl/imc_pkg.sv ***
/*
 * imc_pkg: types for the idle-mode and clock/watchdog configuration block.
 * Assumes imc_cfg.svh for all numbers.
 */
package imc_pkg;

    typedef enum logic [1:0] {IMC_RUN, IMC_IDLE, IMC_SLEEP} imc_pwr_e;

    typedef enum logic [1:0] {IMC_UL_LOCKED, IMC_UL_KEY1, IMC_UL_OPEN} imc_unlock_e;

    typedef enum logic [1:0] {
        IMC_WCLK_SYS   = 2'h0,
        IMC_WCLK_RSVD  = 2'h1,
        IMC_WCLK_FRC   = 2'h2,
        IMC_WCLK_LOW_POWER_RC_OSCILLATOR  = 2'h3
    } imc_wdt_clk_e;

    typedef enum logic [1:0] {
        IMC_PMODE_EXT  = 2'h0,
        IMC_PMODE_STD  = 2'h1,
        IMC_PMODE_HS   = 2'h2,
        IMC_PMODE_OFF  = 2'h3
    } imc_pmode_e;

    // decoded configuration outputs
    typedef struct packed {
        logic         wdt_enable;
        imc_wdt_clk_e wdt_clk_sel;
        logic         wdt_clk_rsvd;
        logic [4:0]   run_ps_exp;
        logic [4:0]   sleep_ps_exp;
        logic         wdt_window_en;
        logic         clk_switch_en;
        logic         fail_safe_mon_en;
        logic         sec_osc_owns_pins;
        logic         clk_out_drive;
        imc_pmode_e   pri_osc_mode;
        logic         two_speed_en;
        logic         sec_osc_en;
        logic         pll_ref_frc;
        logic [2:0]   init_osc_sel;
    } imc_cfg_s;

    typedef struct packed {
        imc_pwr_e     pwr;
        imc_unlock_e  unlock;
        logic         sleep_sel;
        logic [31:0]  wdt_word;
        logic [31:0]  osc_word;
        logic [31:0]  rdata;
        logic         rvalid;
        logic         cpu_halt;
        logic         in_idle;
        logic         in_sleep;
        logic         waitreq;
        logic [7:0]   periph_run;
        imc_cfg_s     cfg;
    } imc_state_s;

endpackage : imc_pkg

// *** dv/imc_tb.sv ***
/*
 * testbench: self-checking bench for imc_top, with register traffic over Avalon-MM,
 * idle and sleep entry and exit, and decode of both configuration words.
 * Assumes imc_cfg.svh and imc_pkg are compiled first; the assertions live in the design.
 */
`timescale 1ns/100ps
`include "imc_cfg.svh"

module testbench;
    logic                   sys_clk;
    logic                   rst_n;
    logic [`IMC_ADDR_W-1:0] avs_address;
    logic                   avs_read;
    logic                   avs_write;
    logic [31:0]            avs_writedata;
    logic [3:0]             avs_byteenable;
    logic [31:0]            avs_readdata;
    logic                   avs_waitrequest;
    logic                   wait_instr;
    logic                   irq_pending;
    logic [2:0]             irq_priority;
    logic [2:0]             cpu_priority;
    logic                   wdt_timeout;
    logic                   soft_reset;
    logic [7:0]             stop_in_idle;
    logic                   cpu_halt;
    logic                   in_idle;
    logic                   in_sleep;
    logic [7:0]             periph_run;
    imc_pkg::imc_cfg_s      cfg;
    int                     num_errors;
    int                     samples_checked;

    imc_top #(.NPERIPH(8)) dut_u (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(avs_byteenable), .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest), .wait_instr_i(wait_instr),
        .irq_pending_i(irq_pending), .irq_priority_i(irq_priority),
        .cpu_priority_i(cpu_priority), .wdt_timeout_i(wdt_timeout),
        .soft_reset_i(soft_reset), .stop_in_idle_i(stop_in_idle), .cpu_halt_o(cpu_halt),
        .in_idle_o(in_idle), .in_sleep_o(in_sleep), .periph_run_o(periph_run), .cfg_o(cfg)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        samples_checked++;
        if (seen !== expected)
        begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    task automatic results();
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // waitrequest is registered: its level just before an edge is what that edge samples
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            check(32'h0000_0001, 32'h0000_0000);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd_check(input logic [3:0] a, input logic [31:0] mask,
                            input logic [31:0] expected);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(q & mask, expected);
    endtask : rd_check

    task automatic set_sleep_sel(input logic v);
        wr(`IMC_OFS_UNLOCK, `IMC_UNLOCK_KEY1);
        wr(`IMC_OFS_UNLOCK, `IMC_UNLOCK_KEY2);
        wr(`IMC_OFS_OSC_CTRL, {27'h0, v, 4'h0});
    endtask : set_sleep_sel

    task automatic enter_wait();
        @(posedge sys_clk);
        wait_instr <= 1'b1;
        @(posedge sys_clk);
        wait_instr <= 1'b0;
        @(negedge sys_clk);
    endtask : enter_wait

    // w = {watchdog time-out, soft reset, interrupt}, raised for one edge
    task automatic wake(input logic [2:0] w);
        @(posedge sys_clk);
        {wdt_timeout, soft_reset, irq_pending} <= w;
        @(posedge sys_clk);
        {wdt_timeout, soft_reset, irq_pending} <= 3'h0;
        @(negedge sys_clk);
    endtask : wake

    task automatic test_reset_values();
        check(32'(cfg.wdt_enable), 32'h1);
        check(32'(cfg.run_ps_exp), 32'(`IMC_PS_MAX));
        check(32'(cfg.pll_ref_frc), 32'h1);
        check({in_idle, in_sleep, cpu_halt, periph_run}, 32'h0000_00FF);
        rd_check(4'h6, 32'hFFFF_FFFF, 32'h0000_0000);
    endtask : test_reset_values

    task automatic test_lock();
        wr(`IMC_OFS_OSC_CTRL, 32'h0000_0010);
        rd_check(`IMC_OFS_OSC_CTRL, 32'h0000_0010, 32'h0000_0000);
        wr(`IMC_OFS_UNLOCK, `IMC_UNLOCK_KEY1);
        wr(`IMC_OFS_UNLOCK, `IMC_UNLOCK_KEY2);
        rd_check(`IMC_OFS_UNLOCK, 32'h0000_0001, 32'h0000_0001);
        wr(`IMC_OFS_OSC_CTRL, 32'h0000_0010);
        rd_check(`IMC_OFS_OSC_CTRL, 32'h0000_0010, 32'h0000_0010);
        set_sleep_sel(1'b0);
        rd_check(`IMC_OFS_OSC_CTRL, 32'h0000_0010, 32'h0000_0000);
    endtask : test_lock

    task automatic test_idle();
        int p;
        @(posedge sys_clk);
        stop_in_idle <= 8'hA5;
        enter_wait();
        check({in_idle, in_sleep, cpu_halt}, 32'h5);
        check(32'(periph_run), 32'h5A);
        @(posedge sys_clk);
        irq_priority <= 3'h7;
        @(negedge sys_clk);
        check(32'(in_idle), 32'h1);
        for (p = 0; p < 5; p++)
        begin
            @(posedge sys_clk);
            irq_priority <= p[2:0];
            wake(3'b001);
            check(32'(in_idle), (p < 4) ? 32'h1 : 32'h0);
        end
        check({cpu_halt, periph_run}, 32'h0FF);
        enter_wait();
        wake(3'b100);
        check({in_idle, cpu_halt}, 32'h0);
        enter_wait();
        wake(3'b010);
        check({in_idle, cpu_halt}, 32'h0);
        enter_wait();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        check({in_idle, cpu_halt, periph_run}, 32'h0FF);
    endtask : test_idle

    task automatic test_sleep();
        set_sleep_sel(1'b1);
        enter_wait();
        check({in_idle, in_sleep, cpu_halt}, 32'h3);
        wake(3'b100);
        check({in_sleep, cpu_halt}, 32'h0);
        set_sleep_sel(1'b0);
    endtask : test_sleep

    task automatic test_words();
        logic [15:0] wv [4] = '{16'h0000, 16'h7F9F, 16'hB380, 16'h4A14};
        logic [15:0] ov [4] = '{16'h0000, 16'h4542, 16'h8281, 16'hD7C7};
        logic [15:0] v;
        int          i;
        for (i = 0; i < 4; i++)
        begin
            v = wv[i];
            wr(`IMC_OFS_WDT_WORD, {16'hFFFF, v});
            repeat (2) @(negedge sys_clk);
            rd_check(`IMC_OFS_WDT_WORD, 32'hFFFF_FFFF, {16'hFFFF, v});
            check(32'(cfg.wdt_enable), 32'(v[15]));
            check({cfg.wdt_clk_sel, cfg.wdt_clk_rsvd}, {v[14:13], v[14:13] == 2'h1});
            check(32'(cfg.run_ps_exp), (v[12:8] > 5'h13) ? 32'h14 : 32'(v[12:8]));
            check(32'(cfg.wdt_window_en), 32'(!v[7]));
            check(32'(cfg.sleep_ps_exp), (v[4:0] > 5'h13) ? 32'h14 : 32'(v[4:0]));
            v = ov[i] | 16'h2828;
            wr(`IMC_OFS_OSC_WORD, {16'hFFFF, v});
            repeat (2) @(negedge sys_clk);
            rd_check(`IMC_OFS_OSC_WORD, 32'hFFFF_FFFF, {16'hFFFF, v});
            check({cfg.clk_switch_en, cfg.fail_safe_mon_en}, {v[14], v[15]});
            check(32'(cfg.sec_osc_owns_pins), 32'(v[12]));
            check(32'(cfg.clk_out_drive), 32'(!v[10]));
            check(32'(cfg.pri_osc_mode), 32'(v[9:8]));
            check({cfg.two_speed_en, cfg.sec_osc_en}, {v[7], v[6]});
            check(32'(cfg.init_osc_sel), 32'(v[2:0]));
        end
        // only lane 1 may change; the other bytes keep the last word
        @(posedge sys_clk);
        avs_byteenable <= 4'h2;
        wr(`IMC_OFS_WDT_WORD, 32'h0000_8000);
        avs_byteenable <= 4'hF;
        rd_check(`IMC_OFS_WDT_WORD, 32'hFFFF_FFFF, 32'hFFFF_8014);
        check(32'(cfg.wdt_enable), 32'h1);
        // the reference only moves on a reset, so the written zero must not show yet
        check(32'(cfg.pll_ref_frc), 32'h1);
        wake(3'b010);
        @(negedge sys_clk);
        check(32'(cfg.pll_ref_frc), 32'h0);
    endtask : test_words

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial
    begin
        #(40 * 20000);
        num_errors++;
        results();
    end

    initial
    begin
        num_errors = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        {avs_read, avs_write, wait_instr, irq_pending, wdt_timeout, soft_reset} = 6'h0;
        avs_address = 4'h0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        irq_priority = 3'h0;
        cpu_priority = 3'h3;
        stop_in_idle = 8'h00;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        test_reset_values();
        test_lock();
        test_idle();
        test_sleep();
        test_words();
        results();
    end
endmodule : testbench
